// >>> logic/serial_mem_slave.sv
// two-wire serial memory slave: addressing, page write, reads
//
// Summary of operation
// - sequential reads wrap within this device, never into another
// - control byte is type code, chip selects, direction; ack on 9th
// - high then low address byte load the pointer, each acknowledged
// - stop after write data starts the write cycle; no acks meanwhile
// - protected writes are acked but discarded; device stays ready
// - after a byte write the pointer holds written address plus one within its page
// - up to 128 bytes go to a page buffer, committed only after stop
// - only the low seven pointer bits count; overflow overwrites
// - page writes stay in one aligned page and wrap to its start
// - write protect covers all; sampled at stop of each write
// - ack polling: control byte gets no ack until the cycle ends
// - a read starts like a write with direction bit set to one
// - the pointer holds last accessed address plus one, wrapping within its page after a write
// - read control is acked, one byte sent; nack plus stop ends it
// - repeated start after address bytes keeps the loaded pointer
// - after a random read the pointer follows the byte read
// - each master ack during a read brings the next byte
// - acked byte at top address wraps the pointer to zero
// - ack only when type code and chip selects match the pins
// - all sixteen address bits count, high byte first
// - after master nack the data line is released high
`timescale 1ns/1ps
`include "see_map.svh"

module serial_mem_slave import see_pkg::*; #(
  parameter logic [3:0] TYPE_CODE   = 4'h5, // arbitrary value
  parameter int         WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic clk_sys,          // system clock, 20 MHz
  input  wire logic rst,              // synchronous reset, high
  input  wire logic scl_in,           // bus clock from the master
  input  wire logic sda_i,            // data line level
  output logic      sda_o,            // data line drive value
  output logic      sda_oe,           // pulls the data line low
  input  wire logic chip_select_low,  // chip select pin 0
  input  wire logic chip_select_mid,  // chip select pin 1
  input  wire logic chip_select_high, // chip select pin 2
  input  wire logic write_protect,    // array write protect pin
  output logic      write_busy        // internal write cycle running
);

  // ************************************************************
  // pin synchronisers and bus events
  // ************************************************************
  logic [`SYNC_BITS-1:0] ff1_r, ff2_r, ff3_r, pin_r;
  logic                  scl_d_r, sda_d_r;
  logic                  scl_f, sda_f, wp_f;
  logic [2:0]            cs_f;
  logic                  scl_rise, scl_fall, start_evt, stop_evt;

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ff1_r   <= '1;
      ff2_r   <= '1;
      ff3_r   <= '1;
      pin_r   <= '1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      ff1_r   <= {chip_select_high, chip_select_mid, chip_select_low,
                  write_protect, sda_i, scl_in};
      ff2_r   <= ff1_r;
      ff3_r   <= ff2_r;
      pin_r   <= (ff2_r & ~(ff2_r ^ ff3_r)) | (pin_r & (ff2_r ^ ff3_r));
      scl_d_r <= pin_r[0];
      sda_d_r <= pin_r[1];
    end
  end

  assign scl_f     = pin_r[0];
  assign sda_f     = pin_r[1];
  assign wp_f      = pin_r[2];
  assign cs_f      = pin_r[5:3];
  assign scl_rise  = scl_f && !scl_d_r;
  assign scl_fall  = !scl_f && scl_d_r;
  assign start_evt = scl_f && scl_d_r && sda_d_r && !sda_f;
  assign stop_evt  = scl_f && scl_d_r && !sda_d_r && sda_f;

  // ************************************************************
  // byte framing and protocol state
  // ************************************************************
  bus_state_t                state_r;
  logic [3:0]                cnt_r;
  logic [7:0]                sh_r, hi_r, tx_sh_r;
  logic                      m_ack_r, busy_r, wr_pend_r;
  logic [`ADDR_BITS-1:0]     addr_ptr_r;
  logic                      ev_byte, ev_ack_end, ctrl_ok, ack_now;
  logic                      tx_load, f_out_valid;
  logic [7:0]                f_out_data, tx_byte;

  assign ev_byte    = scl_fall && (cnt_r == `BIT_ACK);
  assign ev_ack_end = scl_fall && (cnt_r == `BIT_END);
  // busy device answers nothing, which the master polls on
  assign ctrl_ok    = (state_r == ST_CTRL) && (sh_r[7:4] == TYPE_CODE)
                      && (sh_r[3:1] == cs_f) && !busy_r;
  assign ack_now    = ctrl_ok || (state_r == ST_ADDR_HI)
                      || (state_r == ST_ADDR_LO) || (state_r == ST_WDATA);
  assign tx_load    = ev_ack_end && (state_r == ST_RDATA) && m_ack_r;
  assign tx_byte    = f_out_valid ? f_out_data : `NO_DATA;

  // bit counter: data bits on rises 0..7, acknowledge on rise 8
  always_ff @(posedge clk_sys) begin
    if (rst || start_evt) begin
      cnt_r <= '0;
    end else if (ev_ack_end) begin
      cnt_r <= '0;
    end else if (scl_rise && (cnt_r != `BIT_END)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // receive shifter and master acknowledge sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sh_r    <= '0;
      m_ack_r <= 1'b0;
    end else if (scl_rise && (cnt_r < `BIT_ACK)) begin
      sh_r <= {sh_r[6:0], sda_f};
    end else if (scl_rise && (cnt_r == `BIT_ACK)) begin
      m_ack_r <= !sda_f;
    end
  end

  // command sequence; a repeated start keeps the pointer
  always_ff @(posedge clk_sys) begin
    if (rst || stop_evt) begin
      state_r <= ST_IDLE;
    end else if (start_evt) begin
      state_r <= ST_CTRL;
    end else if (ev_byte) begin
      case (state_r)
        ST_CTRL: begin
          if (!ctrl_ok) begin
            state_r <= ST_IDLE;
          end else if (sh_r[0]) begin
            state_r <= ST_RDATA;
          end else begin
            state_r <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          state_r <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          state_r <= ST_WDATA;
        end
        default: begin
          state_r <= state_r;
        end
      endcase
    end else if (ev_ack_end && (state_r == ST_RDATA) && !m_ack_r) begin
      state_r <= ST_IDLE;
    end
  end

  // high address byte, held until the low byte arrives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hi_r <= '0;
    end else if (ev_byte && (state_r == ST_ADDR_HI)) begin
      hi_r <= sh_r;
    end
  end

  // address pointer: loads, page-local write count, read count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_ptr_r <= '0;
    end else if (ev_byte && (state_r == ST_ADDR_LO)) begin
      addr_ptr_r <= {hi_r, sh_r};
    end else if (ev_byte && (state_r == ST_WDATA)) begin
      addr_ptr_r[6:0] <= addr_ptr_r[6:0] + 7'h01;
    end else if (tx_load) begin
      addr_ptr_r <= addr_ptr_r + 16'h0001;
    end
  end

  // transmit shifter, next bit sits in bit 6
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_sh_r <= `NO_DATA;
    end else if (tx_load) begin
      tx_sh_r <= tx_byte;
    end else if (scl_fall && (state_r == ST_RDATA) && (cnt_r != 4'h0)
                 && (cnt_r < `BIT_ACK)) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b1};
    end
  end

  // open-drain data drive: acks and zero bits pull low
  always_ff @(posedge clk_sys) begin
    if (rst || start_evt || stop_evt) begin
      sda_oe <= 1'b0;
    end else if (ev_byte) begin
      sda_oe <= (state_r != ST_RDATA) && ack_now;
    end else if (ev_ack_end) begin
      sda_oe <= tx_load && !tx_byte[7];
    end else if (scl_fall && (state_r == ST_RDATA) && (cnt_r != 4'h0)
                 && (cnt_r < `BIT_ACK)) begin
      sda_oe <= !tx_sh_r[6];
    end
  end

  // the pin only ever pulls low
  always_ff @(posedge clk_sys) begin
    sda_o <= 1'b0;
  end

  // ************************************************************
  // page buffer and self-timed write cycle
  // ************************************************************
  logic [127:0]               pb_valid_r;
  logic [8:0]                 base_r;
  logic                       cm_act_r, cm_wr_r, commit_go;
  logic [6:0]                 cm_idx_r, cm_widx_r;
  logic [23:0]                timer_r;
  logic [7:0]                 pb_rdata, arr_rdata;
  logic                       pb_we;
  logic [`PAGE_BITS-1:0]      pb_addr;
  logic [`ADDR_BITS-1:0]      arr_addr, fetch_ptr_r;

  assign pb_we     = ev_byte && (state_r == ST_WDATA);
  assign pb_addr   = busy_r ? cm_idx_r : addr_ptr_r[6:0];
  // protection is looked at only here, at the stop
  assign commit_go = stop_evt && (state_r == ST_WDATA) && wr_pend_r
                     && !wp_f;

  // a write needs one acked data byte; repeated start drops it
  always_ff @(posedge clk_sys) begin
    if (rst || start_evt || stop_evt) begin
      wr_pend_r <= 1'b0;
    end else if (pb_we) begin
      wr_pend_r <= 1'b1;
    end
  end

  // slot valid bits; a wrapped byte replaces the earlier one
  always_ff @(posedge clk_sys) begin
    if (rst || (ev_byte && (state_r == ST_ADDR_LO))) begin
      pb_valid_r <= '0;
    end else if (pb_we) begin
      pb_valid_r[addr_ptr_r[6:0]] <= 1'b1;
    end
  end

  // commit walk over all slots, then the timed wait
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r    <= 1'b0;
      cm_act_r  <= 1'b0;
      cm_idx_r  <= '0;
      cm_wr_r   <= 1'b0;
      cm_widx_r <= '0;
      base_r    <= '0;
      timer_r   <= '0;
    end else begin
      cm_wr_r   <= cm_act_r && pb_valid_r[cm_idx_r];
      cm_widx_r <= cm_idx_r;
      if (commit_go) begin
        busy_r   <= 1'b1;
        cm_act_r <= 1'b1;
        cm_idx_r <= '0;
        base_r   <= addr_ptr_r[15:7];
      end else if (cm_act_r) begin
        cm_idx_r <= cm_idx_r + 7'h01;
        if (cm_idx_r == `PAGE_LAST) begin
          cm_act_r <= 1'b0;
          timer_r  <= 24'(WRITE_CYCLES);
        end
      end else if (busy_r && !cm_wr_r) begin
        if (timer_r == '0) begin
          busy_r <= 1'b0;
        end else begin
          timer_r <= timer_r - 24'h000001;
        end
      end
    end
  end

  // busy flag to the pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_busy <= 1'b0;
    end else begin
      write_busy <= busy_r;
    end
  end

  byte_ram #(.AW(`PAGE_BITS), .DW(8)) u_page (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (pb_we),
    .addr    (pb_addr),
    .wdata   (sh_r),
    .rdata   (pb_rdata)
  );

  assign arr_addr = cm_wr_r ? {base_r, cm_widx_r} : fetch_ptr_r;

  byte_ram #(.AW(`ADDR_BITS), .DW(8)) u_array (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (cm_wr_r),
    .addr    (arr_addr),
    .wdata   (pb_rdata),
    .rdata   (arr_rdata)
  );

  // ************************************************************
  // read prefetch into the fifo
  // ************************************************************
  logic fetch_on_r, rd_pend_r, f_in_ready, f_in_valid, issue;

  assign issue      = fetch_on_r && !rd_pend_r && f_in_ready;
  assign f_in_valid = rd_pend_r && fetch_on_r;

  // prefetch runs from read control ack to the end of the read
  always_ff @(posedge clk_sys) begin
    if (rst || start_evt || stop_evt) begin
      fetch_on_r  <= 1'b0;
      rd_pend_r   <= 1'b0;
      fetch_ptr_r <= '0;
    end else if (ev_byte && ctrl_ok && sh_r[0]) begin
      fetch_on_r  <= 1'b1;
      rd_pend_r   <= 1'b0;
      fetch_ptr_r <= addr_ptr_r;
    end else if (ev_ack_end && (state_r == ST_RDATA) && !m_ack_r) begin
      fetch_on_r <= 1'b0;
      rd_pend_r  <= 1'b0;
    end else begin
      rd_pend_r <= issue;
      if (issue) begin
        fetch_ptr_r <= fetch_ptr_r + 16'h0001;
      end
    end
  end

  sync_fifo #(.W(8), .D(`FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (!fetch_on_r),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (arr_rdata),
    .out_valid (f_out_valid),
    .out_ready (tx_load),
    .out_data  (f_out_data)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ack_match;
    ev_byte && ctrl_ok |=> sda_oe ##1 sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("matching control byte not acknowledged");

  property p_no_ack_mismatch;
    ev_byte && (state_r == ST_CTRL) && !ctrl_ok |=> !sda_oe;
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch)
    else $error("control byte acked without a match");

  property p_quiet_busy;
    busy_r |-> !sda_oe;
  endproperty
  a_quiet_busy: assert property (p_quiet_busy)
    else $error("data line driven during write cycle");

  property p_protect;
    stop_evt && (state_r == ST_WDATA) && wr_pend_r && wp_f
      |=> !busy_r [*3];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write started a cycle");

  property p_commit;
    stop_evt && (state_r == ST_WDATA) && wr_pend_r && !wp_f
      |=> busy_r [*8];
  endproperty
  a_commit: assert property (p_commit)
    else $error("write cycle not started at stop");

  property p_page_count;
    pb_we |=> (addr_ptr_r[15:7] == $past(addr_ptr_r[15:7]))
      && (addr_ptr_r[6:0] == $past(addr_ptr_r[6:0]) + 7'h01);
  endproperty
  a_page_count: assert property (p_page_count)
    else $error("page write pointer left its page");

  property p_addr_load;
    ev_byte && (state_r == ST_ADDR_LO)
      |=> addr_ptr_r == {$past(hi_r), $past(sh_r)};
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address bytes not loaded high first");

  property p_read_step;
    tx_load |=> addr_ptr_r == $past(addr_ptr_r) + 16'h0001;
  endproperty
  a_read_step: assert property (p_read_step)
    else $error("pointer not stepped after byte sent");

  property p_release;
    ev_ack_end && (state_r == ST_RDATA) && !m_ack_r
      |=> !sda_oe && (state_r == ST_IDLE);
  endproperty
  a_release: assert property (p_release)
    else $error("data line not released after nack");

  property p_timed;
    $fell(cm_act_r) |-> busy_r [*8];
  endproperty
  a_timed: assert property (p_timed)
    else $error("write cycle ended before its wait");

  c_read_ack: cover property (ev_byte && ctrl_ok && sh_r[0]);
  c_commit:   cover property (commit_go);
  c_seq_read: cover property (tx_load ##[1:300] tx_load);
  c_poll:     cover property (ev_byte && (state_r == ST_CTRL) && busy_r);

endmodule

// >>> logic/see_map.svh
// constants of the two-wire serial memory slave
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

`define ADDR_BITS      16
`define PAGE_BITS      7
`define PAGE_LAST      7'h7F
`define FIFO_DEPTH     8
`define SYNC_BITS      6
`define BIT_ACK        4'h8
`define BIT_END        4'h9
`define CLK_PERIOD_NS  50
`define WRITE_TIME_NS  1000000
`define NO_DATA        8'hFF

`endif

// >>> logic/see_pkg.sv
// types of the two-wire serial memory slave
package see_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA
  } bus_state_t;

endpackage

// >>> logic/byte_ram.sv
// single-port memory with registered read data
`timescale 1ns/1ps

module byte_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk_sys, // system clock
  input  wire logic          rst,     // synchronous reset, high
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] addr,    // word address
  input  wire logic [DW-1:0] wdata,   // write data
  output logic      [DW-1:0] rdata    // read data, one cycle late
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ************************************************************
  // storage
  // ************************************************************
  // array write
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule

// >>> logic/sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps

module sync_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_sys,   // system clock
  input  wire logic         rst,       // synchronous reset, high
  input  wire logic         flush,     // empties the fifo
  input  wire logic         in_valid,  // write side valid
  output logic              in_ready,  // not full
  input  wire logic [W-1:0] in_data,   // write data
  output logic              out_valid, // not empty
  input  wire logic         out_ready, // read side takes a word
  output logic      [W-1:0] out_data   // head word
);

  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
  localparam logic [AW-1:0] LAST_C = AW'(D - 1);

  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  // ************************************************************
  // flags and handshakes
  // ************************************************************
  assign in_ready  = (count_r != DEPTH_C);
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_r    <= '0;
      rd_r    <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST_C) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == LAST_C) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// >>> sim/bus_master.sv
// two-wire bus master model driving clock and data
`timescale 1ns/1ps

// the slave answers five clocks after it sees a fall, so the low phase
// is the long one; low plus high stays eight clocks, 400 ns
module bus_master #(
  parameter int LOW  = 6, // system clocks with the bus clock low
  parameter int HIGH = 2  // system clocks with the bus clock high
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic sda_line, // resolved data line
  output logic      scl,      // bus clock, still and high when idle
  output logic      sda_low   // pulls the data line low
);
  // ******************************
  // bus idle at time zero
  // ******************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // waits n clocks, then steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // start from idle or repeated start from a low clock
  task automatic start();
    tick(1);
    sda_low = 1'b0;
    tick(LOW - 1);
    scl = 1'b1;
    tick(HIGH);
    sda_low = 1'b1;
    tick(HIGH);
    scl = 1'b0;
  endtask

  // one bit: data set while low, held through high, sampled at its end
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sda_low = !b;
    tick(LOW - 1);
    scl = 1'b1;
    tick(HIGH);
    s = sda_line;
    scl = 1'b0;
  endtask

  // byte out msb first, then ninth clock returns the acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // byte in msb first, then own acknowledge or its absence
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask

  // stop: data rises while clock is high, then the bus stands idle
  task automatic stop();
    tick(1);
    sda_low = 1'b1;
    tick(LOW - 1);
    scl = 1'b1;
    tick(HIGH);
    sda_low = 1'b0;
    tick(LOW);
  endtask
endmodule

// >>> sim/test_serial_mem_slave.sv
// self-checking testbench of the two-wire serial memory slave
`timescale 1ns/1ps

module test_serial_mem_slave;
  localparam logic [3:0] TC   = 4'h5; // arbitrary type code
  localparam int         WCYC = 20;   // short write cycle

  logic       clk_sys;        // system clock
  logic       rst;            // synchronous reset
  logic [2:0] cs;             // chip select pins
  logic       wp;             // write protect pin
  logic       sda_o;          // device drive value
  logic       sda_oe;         // device pulls low
  logic       busy;           // write cycle running
  logic       scl;            // bus clock
  logic       m_low;          // master pulls low
  wire        sda_line;       // resolved line with pull-up
  logic       ack;            // last acknowledge seen
  logic [7:0] rd;             // last byte read
  logic [7:0] q[$];           // bytes to send or expect
  int         err_count = 0;
  int         num_checks = 0;

  // ******************************
  // design, master and open-drain line
  // ******************************
  serial_mem_slave #(.TYPE_CODE(TC), .WRITE_CYCLES(WCYC)) i_serial_mem_slave (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_low(cs[0]),
    .chip_select_mid(cs[1]), .chip_select_high(cs[2]),
    .write_protect(wp), .write_busy(busy));
  bus_master i_bus_master (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(m_low));
  assign sda_line = !(m_low || (sda_oe && !sda_o));

  // clock at 20 MHz
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ******************************
  // checking and helpers
  // ******************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // start plus control byte, acknowledge compared with exp
  task automatic ctrl(input logic rw, input logic [3:0] tc,
                      input logic [2:0] c, input logic exp);
    i_bus_master.start();
    i_bus_master.put({tc, c, rw}, ack);
    check(ack, exp);
  endtask

  task automatic set_addr(input logic [15:0] a);
    ctrl(1'b0, TC, cs, 1'b1);
    i_bus_master.put(a[15:8], ack);
    check(ack, 1'b1);
    i_bus_master.put(a[7:0], ack);
    check(ack, 1'b1);
  endtask

  // bounded wait for the end of the write cycle
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    if (n == 1000) begin
      err_count++;
      $display("ERROR t=%0t write cycle never ended", $time);
      print_verdict();
    end
  endtask

  // writes q from a; wp flips after stop to show it was sampled there
  task automatic write_bytes(input logic [15:0] a);
    logic p;
    p = wp;
    set_addr(a);
    foreach (q[i]) begin
      i_bus_master.put(q[i], ack);
      check(ack, 1'b1);
    end
    i_bus_master.stop();
    wp = !p;
    ctrl(1'b0, TC, cs, p);
    check(busy, !p);
    i_bus_master.stop();
    wait_idle();
    ctrl(1'b0, TC, cs, 1'b1);
    i_bus_master.stop();
    wp = 1'b0;
  endtask

  // read control, bytes compared with q, master nack on the last
  task automatic reads();
    ctrl(1'b1, TC, cs, 1'b1);
    foreach (q[i]) begin
      i_bus_master.get(i != q.size() - 1, rd);
      check(rd, q[i]);
    end
    i_bus_master.tick(8);
    check(sda_oe, 1'b0);
    check(sda_o, 1'b0);
    check(sda_line, 1'b1);
    i_bus_master.stop();
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic t_select();
    for (int i = 0; i < 3; i++) begin
      ctrl(1'b0, TC, cs ^ 3'(1 << i), 1'b0);
    end
    ctrl(1'b1, TC ^ 4'h1, cs, 1'b0);
    ctrl(1'b0, TC, cs, 1'b1);
    i_bus_master.stop();
  endtask

  // crosses a page end on purpose, then random and current reads
  task automatic t_page();
    q = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4};
    write_bytes(16'h007E);
    q = '{8'hA0, 8'hA1};
    set_addr(16'h007E);
    reads();
    q = '{8'hA2};
    set_addr(16'h0000);
    reads();
    q = '{8'hA3};
    reads();
  endtask

  task automatic t_protect();
    wp = 1'b1;
    q = '{8'h55};
    write_bytes(16'h0000);
    q = '{8'hA2};
    set_addr(16'h0000);
    reads();
  endtask

  // 129 bytes into one page: the first slot is overwritten
  task automatic t_overflow();
    q = {};
    for (int i = 0; i < 129; i++) begin
      q.push_back(8'(i));
    end
    write_bytes(16'h0100);
    q = '{8'h80, 8'h01};
    set_addr(16'h0100);
    reads();
  endtask

  task automatic t_wrap();
    q = '{8'h77};
    write_bytes(16'h0001);
    q = '{8'hA4};
    reads();
    q = '{8'h5A};
    write_bytes(16'hFFFF);
    q = '{8'h5A, 8'hA2, 8'h77};
    set_addr(16'hFFFF);
    reads();
  endtask

  // reset for three clocks, idle bus, then every scenario
  initial begin
    rst = 1'b1;
    cs = 3'b101;
    wp = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    t_select();
    t_page();
    t_protect();
    t_overflow();
    t_wrap();
    print_verdict();
  end
endmodule
